// *** ptb_top.sv ***
// Periodic tick unit: APB register slave, control state and mode gating.
`timescale 1ns/1ns
`include "ptb_map.svh"
module ptb_top #(
    parameter int STAGES = `PTB_CHAIN_STAGES,
    parameter int PRE_BITS = `PTB_PRESCALE_BITS,
    parameter int MISS_BITS = 8
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic reference_clock_i,
    input wire logic extra_prescale_option_i,
    input wire logic osc_in_stop_option_i,
    input wire logic wait_mode_i,
    input wire logic stop_mode_i,
    output logic tick_irq_o,
    output logic stop_wakeup_o
);
    import ptb_pkg::*;

    if (MISS_BITS < 1 || MISS_BITS > 16) begin : g_bad_miss
        $error("ptb_top miss counter width must be 1 to 16");
    end

    // Pin-level inputs: reference clock and the two static options.
    logic [2:0] pins_raw;
    logic [2:0] pins_sync;
    logic ref_level;
    logic prescale_opt;
    logic osc_stop_opt;

    assign pins_raw = {osc_in_stop_option_i, extra_prescale_option_i, reference_clock_i};

    ptb_sync #(
        .WIDTH(3)
    ) u_sync (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .async_i(pins_raw),
        .sync_o(pins_sync)
    );

    assign ref_level = pins_sync[0];
    assign prescale_opt = pins_sync[1]; // [RULE19]
    assign osc_stop_opt = pins_sync[2]; // [RULE19]

    // Edge detect on the synchronised reference level.
    logic ref_prev;
    logic next_ref_prev;
    logic ref_edge;
    logic ref_running;
    logic counting_edge;

    always_comb begin
        next_ref_prev = ref_level;
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ref_prev <= 1'b0;
        end else if (ce_i) begin
            ref_prev <= next_ref_prev;
        end
    end

    assign ref_edge = ref_level & ~ref_prev;
    // In stop mode the reference only runs when the oscillator is kept alive.
    assign ref_running = ~stop_mode_i | osc_stop_opt; // [RULE15]
    // Wait mode does not gate the edge, so counting carries on there.
    assign counting_edge = ref_edge & ref_running; // [RULE14] [RULE8]

    // Control register state.
    logic unit_enable;
    logic irq_enable;
    ptb_tap_type tap_select;
    logic pending;
    logic [MISS_BITS-1:0] miss_count;
    logic next_unit_enable;
    logic next_irq_enable;
    ptb_tap_type next_tap_select;
    logic next_pending;
    logic [MISS_BITS-1:0] next_miss_count;

    // Divider chain.
    logic tick;
    logic [STAGES-1:0] chain_count;

    ptb_divider #(
        .STAGES(STAGES),
        .PRE_BITS(PRE_BITS)
    ) u_divider (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .clear_i(~unit_enable),
        .ref_edge_i(counting_edge),
        .prescale_i(prescale_opt),
        .tap_i(tap_select),
        .tick_o(tick),
        .count_o(chain_count)
    );

    // APB access control.
    ptb_apb_state_type apb_state;
    ptb_apb_state_type next_apb_state;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic bus_blocked;
    logic addr_known;
    logic access_cycle;
    logic commit;
    logic wr_control;
    logic low_lane;

    // The core cannot reach the register in wait or stop mode.
    assign bus_blocked = wait_mode_i | stop_mode_i; // [RULE14] [RULE16]

    always_comb begin
        case (paddr_i)
            `PTB_OFS_CONTROL: addr_known = 1'b1;
            `PTB_OFS_STATUS: addr_known = 1'b1;
            `PTB_OFS_COUNT: addr_known = 1'b1;
            `PTB_OFS_RATIO: addr_known = 1'b1;
            default: addr_known = 1'b0;
        endcase
    end

    assign access_cycle = psel_i & penable_i;
    assign pready_o = access_cycle & (apb_state == PTB_APB_DONE);
    assign commit = pready_o & ~pslverr_o;
    assign low_lane = pstrb_i[0];
    assign wr_control = commit & pwrite_i & low_lane & (paddr_i == `PTB_OFS_CONTROL);

    // Division ratio currently selected, shown to software for convenience.
    logic [23:0] ratio;

    always_comb begin
        ratio = 24'(32'h2 << ptb_tap_bit(tap_select));
        if (prescale_opt) begin
            ratio = 24'({ratio, 7'h00}); // [RULE6]
        end
    end

    // Read multiplexer; the acknowledge position always returns zero.
    function automatic logic [31:0] read_word(
        input logic [11:0] addr,
        input logic en,
        input logic ie,
        input ptb_tap_type tap,
        input logic flag,
        input logic [MISS_BITS-1:0] miss,
        input logic [STAGES-1:0] cnt,
        input logic [23:0] rat,
        input logic pre_opt,
        input logic osc_opt
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        case (addr)
            `PTB_OFS_CONTROL: begin
                w[`PTB_BIT_FLAG] = flag; // [RULE18]
                w[`PTB_BIT_TAP_HI:`PTB_BIT_TAP_LO] = tap;
                w[`PTB_BIT_ACK] = 1'b0; // [RULE4]
                w[`PTB_BIT_IRQ_EN] = ie;
                w[`PTB_BIT_UNIT_EN] = en;
            end
            `PTB_OFS_STATUS: begin
                w[0] = flag;
                w[1] = pre_opt;
                w[2] = osc_opt;
                w[15:8] = 8'(miss);
            end
            `PTB_OFS_COUNT: begin
                w[STAGES-1:0] = cnt;
            end
            `PTB_OFS_RATIO: begin
                w[23:0] = rat;
            end
            default: begin
                w = 32'h0000_0000;
            end
        endcase
        return w;
    endfunction

    // One wait state: the read word is captured before pready rises.
    always_comb begin
        next_apb_state = apb_state;
        next_prdata = prdata_o;
        next_pslverr = pslverr_o;
        case (apb_state)
            PTB_APB_IDLE: begin
                if (access_cycle) begin
                    next_apb_state = PTB_APB_DONE;
                    next_pslverr = bus_blocked | ~addr_known; // [RULE16]
                    next_prdata = 32'h0000_0000;
                    if (!pwrite_i && !bus_blocked) begin
                        next_prdata = read_word(paddr_i, unit_enable, irq_enable,
                            tap_select, pending, miss_count, chain_count, ratio,
                            prescale_opt, osc_stop_opt);
                    end
                end
            end
            PTB_APB_DONE: begin
                next_apb_state = PTB_APB_IDLE;
                next_pslverr = 1'b0;
            end
            default: begin
                next_apb_state = PTB_APB_IDLE;
                next_pslverr = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            apb_state <= PTB_APB_IDLE;
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else if (ce_i) begin
            apb_state <= next_apb_state;
            prdata_o <= next_prdata;
            pslverr_o <= next_pslverr;
        end
    end

    // Control fields, pending flag and the missed-tick counter.
    always_comb begin
        next_unit_enable = unit_enable;
        next_irq_enable = irq_enable;
        next_tap_select = tap_select;
        next_pending = pending;
        next_miss_count = miss_count;
        if (wr_control) begin
            next_unit_enable = pwdata_i[`PTB_BIT_UNIT_EN];
            next_irq_enable = pwdata_i[`PTB_BIT_IRQ_EN];
            // Tap changes while running are accepted but may give one odd period.
            next_tap_select = pwdata_i[`PTB_BIT_TAP_HI:`PTB_BIT_TAP_LO]; // [RULE9]
            // Writes to the flag position are ignored; only an acknowledge clears.
            if (pwdata_i[`PTB_BIT_ACK]) begin
                next_pending = 1'b0; // [RULE3] [RULE18]
                next_miss_count = '0;
            end
        end
        if (tick && unit_enable) begin
            next_pending = 1'b1; // [RULE1]
            if (pending && !(&miss_count)) begin
                next_miss_count = MISS_BITS'(miss_count + 1'b1);
            end
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            unit_enable <= 1'(`PTB_RST_CONTROL >> `PTB_BIT_UNIT_EN); // [RULE12]
            irq_enable <= 1'(`PTB_RST_CONTROL >> `PTB_BIT_IRQ_EN); // [RULE13]
            tap_select <= `PTB_RST_TAP;
            pending <= 1'b0;
            miss_count <= '0;
        end else if (ce_i) begin
            unit_enable <= next_unit_enable;
            irq_enable <= next_irq_enable;
            tap_select <= next_tap_select;
            pending <= next_pending;
            miss_count <= next_miss_count;
        end
    end

    // Request outputs, registered so that they stay glitch free.
    logic next_irq;
    logic next_wakeup;

    always_comb begin
        next_irq = pending & irq_enable; // [RULE2]
        next_wakeup = next_irq & stop_mode_i & osc_stop_opt; // [RULE15]
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tick_irq_o <= 1'b0;
            stop_wakeup_o <= 1'b0;
        end else if (ce_i) begin
            tick_irq_o <= next_irq;
            stop_wakeup_o <= next_wakeup;
        end
    end
endmodule

// *** ptb_map.svh ***
// Offsets, field positions, reset values and counts of the periodic tick unit.
// Operation
// (RULE1) Flag set on rollover at selected tap
// (RULE2) Pending flag and enable raise interrupt request
// (RULE3) Writing one to acknowledge clears flag
// (RULE4) Acknowledge bit is write-only, reads zero
// (RULE5) Codes 0-6 divide 32768 down to 16
// (RULE6) Prescale on: codes divide 4194304 to 1024
// (RULE7) Code 7 without prescale divides by eight
// (RULE8) Period equals ratio times reference period
// (RULE9) Software changes tap only while disabled
// (RULE10) Counter held zero while unit disabled
// (RULE11) First flag at half period, then exact
// (RULE12) Reset clears unit enable
// (RULE13) Reset clears interrupt enable
// (RULE14) Wait mode keeps counting, register blocked
// (RULE15) Stop mode runs only with oscillator option
// (RULE16) Stop mode blocks register access
// (RULE17) Software disables unit before low power
// (RULE18) Pending flag read-only, shows pending state
// (RULE19) Option inputs are static, sampled externally
`ifndef PTB_MAP_SVH
`define PTB_MAP_SVH

`define PTB_OFS_CONTROL 12'h000
`define PTB_OFS_STATUS 12'h004
`define PTB_OFS_COUNT 12'h008
`define PTB_OFS_RATIO 12'h00C

`define PTB_BIT_FLAG 7
`define PTB_BIT_TAP_HI 6
`define PTB_BIT_TAP_LO 4
`define PTB_BIT_ACK 3
`define PTB_BIT_IRQ_EN 2
`define PTB_BIT_UNIT_EN 1

`define PTB_RST_CONTROL 8'h00
`define PTB_RST_TAP 3'h0

`define PTB_CHAIN_STAGES 15
`define PTB_PRESCALE_BITS 7
`define PTB_REF_SYNC_STAGES 2

`endif

// *** ptb_pkg.sv ***
// Types and the tap decode shared by the periodic tick unit.
package ptb_pkg;
    typedef logic [2:0] ptb_tap_type;
    typedef enum logic [1:0] {
        PTB_APB_IDLE = 2'b01,
        PTB_APB_DONE = 2'b10
    } ptb_apb_state_type;

    // Chain bit whose rising edge marks a tick for each tap code.
    function automatic logic [3:0] ptb_tap_bit(input ptb_tap_type sel);
        case (sel)
            3'h0: ptb_tap_bit = 4'hE;
            3'h1: ptb_tap_bit = 4'hC;
            3'h2: ptb_tap_bit = 4'hA;
            3'h3: ptb_tap_bit = 4'h6;
            3'h4: ptb_tap_bit = 4'h5;
            3'h5: ptb_tap_bit = 4'h4;
            3'h6: ptb_tap_bit = 4'h3;
            default: ptb_tap_bit = 4'h2;
        endcase
    endfunction
endpackage

// *** ptb_sync.sv ***
// Two-flop synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/1ns
module ptb_sync #(
    parameter int WIDTH = 1
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    always_comb begin
        next_meta = ce_i ? async_i : meta;
        next_sync = ce_i ? meta : sync_o;
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta <= '0;
            sync_o <= '0;
        end else begin
            meta <= next_meta;
            sync_o <= next_sync;
        end
    end
endmodule

// *** ptb_divider.sv ***
// Optional divide-by-128 prescaler and fifteen-stage tap chain.
`timescale 1ns/1ns
`include "ptb_map.svh"
module ptb_divider #(
    parameter int STAGES = `PTB_CHAIN_STAGES,
    parameter int PRE_BITS = `PTB_PRESCALE_BITS
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic clear_i,
    input wire logic ref_edge_i,
    input wire logic prescale_i,
    input wire ptb_pkg::ptb_tap_type tap_i,
    output logic tick_o,
    output logic [STAGES-1:0] count_o
);
    import ptb_pkg::*;

    if (STAGES != 15 || PRE_BITS < 1) begin : g_bad_size
        $error("ptb_divider needs fifteen stages and a prescaler");
    end

    logic [PRE_BITS-1:0] pre;
    logic [PRE_BITS-1:0] next_pre;
    logic [STAGES-1:0] next_count;
    logic next_tick;
    logic advance;
    logic [3:0] bit_sel;
    logic [STAGES-1:0] low_mask;
    logic [STAGES-1:0] tap_hit;

    always_comb begin
        next_pre = pre;
        next_count = count_o;
        next_tick = 1'b0;
        advance = 1'b0;
        bit_sel = ptb_tap_bit(tap_i);
        low_mask = STAGES'((32'h2 << bit_sel) - 32'h1);
        tap_hit = STAGES'(32'h1 << bit_sel);
        if (clear_i) begin
            next_pre = '0; // [RULE10]
            next_count = '0; // [RULE10]
        end else if (ref_edge_i) begin
            next_pre = PRE_BITS'(pre + 1'b1);
            advance = prescale_i ? (&pre) : 1'b1; // [RULE6]
            if (advance) begin
                next_count = STAGES'(count_o + 1'b1);
                // Rising tap bit: half a period first, then whole periods.
                next_tick = ((next_count & low_mask) == tap_hit); // [RULE1] [RULE5] [RULE7] [RULE11]
            end
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pre <= '0;
            count_o <= '0;
            tick_o <= 1'b0;
        end else if (ce_i) begin
            pre <= next_pre;
            count_o <= next_count;
            tick_o <= next_tick;
        end
    end
endmodule

// *** ptb_top_asserts.sv ***
// Port-level assertions of the periodic tick unit and the bind that attaches them.
`timescale 1ns/1ns
`include "ptb_map.svh"
module ptb_top_asserts #(
    parameter int STAGES = `PTB_CHAIN_STAGES,
    parameter int PRE_BITS = `PTB_PRESCALE_BITS,
    parameter int MISS_BITS = 8
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic reference_clock_i,
    input wire logic extra_prescale_option_i,
    input wire logic osc_in_stop_option_i,
    input wire logic wait_mode_i,
    input wire logic stop_mode_i,
    input wire logic tick_irq_o,
    input wire logic stop_wakeup_o
);
    logic en_seen, ie_seen, next_en_seen, next_ie_seen, ctl_wr;
    assign ctl_wr = pready_o && pwrite_i && !pslverr_o && pstrb_i[0] && paddr_i == 12'h000;
    always_comb begin
        next_en_seen = ctl_wr ? pwdata_i[`PTB_BIT_UNIT_EN] : en_seen;
        next_ie_seen = ctl_wr ? pwdata_i[`PTB_BIT_IRQ_EN] : ie_seen;
    end
    // Shadows of accepted control writes let the masks be judged from the bus alone.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            en_seen <= 1'b0;
            ie_seen <= 1'b0;
        end else if (ce_i) begin
            en_seen <= next_en_seen;
            ie_seen <= next_ie_seen;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    chk_ready_wait: assert property (pready_o |-> psel_i && penable_i && $past(penable_i))
        else $error("ready came without a waited access cycle");
    chk_ready_once: assert property (ce_i && psel_i && penable_i && !$past(penable_i)
        |=> pready_o ##1 !pready_o)
        else $error("ready not one cycle after the first access cycle");
    chk_irq_masked: assert property (!ie_seen |=> !tick_irq_o)
        else $error("interrupt request while masked");
    chk_ack_reads: assert property (pready_o && !pwrite_i && paddr_i == 12'h000 |-> !prdata_o[3])
        else $error("acknowledge bit read back as one");
    chk_count_held: assert property (pready_o && !pwrite_i && paddr_i == 12'h008 && !pslverr_o
        && !en_seen && !$past(en_seen, 3) |-> prdata_o == 32'h0)
        else $error("counter not zero while disabled");
    chk_mode_block: assert property (pready_o && $past(wait_mode_i || stop_mode_i) |-> pslverr_o)
        else $error("register reached in a low power mode");
    chk_refused_zero: assert property (pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
        else $error("refused read returned data");
    chk_reset_quiet: assert property ($rose(reset_n_i) |-> (!tick_irq_o && !stop_wakeup_o) [*3])
        else $error("request active just after reset");
    chk_wake_cause: assert property (stop_wakeup_o |-> $past(stop_mode_i))
        else $error("wakeup outside stop mode");
    cov_irq: cover property ($rose(tick_irq_o));
    cov_err: cover property (pready_o && pslverr_o);
    cov_wake: cover property ($rose(stop_wakeup_o));
endmodule

bind ptb_top ptb_top_asserts #(.STAGES(STAGES), .PRE_BITS(PRE_BITS), .MISS_BITS(MISS_BITS))
    u_asserts (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .reference_clock_i(reference_clock_i), .extra_prescale_option_i(extra_prescale_option_i),
    .osc_in_stop_option_i(osc_in_stop_option_i), .wait_mode_i(wait_mode_i),
    .stop_mode_i(stop_mode_i), .tick_irq_o(tick_irq_o), .stop_wakeup_o(stop_wakeup_o));

// *** ptb_top_tb.sv ***
// Self-checking bench for the periodic tick unit.
`timescale 1ns/1ns
module ptb_top_tb;
    logic mclk_i, reset_n_i, ce_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, er;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic [3:0] pstrb_i;
    logic reference_clock_i, extra_prescale_option_i, osc_in_stop_option_i;
    logic wait_mode_i, stop_mode_i, tick_irq_o, stop_wakeup_o;
    int failures, compares;
    // Each row: prescale option, tap code, expected division ratio.
    logic [27:0] rows [16] = '{28'h0008000, 28'h1002000, 28'h2000800, 28'h3000080,
        28'h4000040, 28'h5000020, 28'h6000010, 28'h7000008, 28'h8400000, 28'h9100000,
        28'hA040000, 28'hB004000, 28'hC002000, 28'hD001000, 28'hE000800, 28'hF000400};

    ptb_top dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .reference_clock_i(reference_clock_i), .extra_prescale_option_i(extra_prescale_option_i),
        .osc_in_stop_option_i(osc_in_stop_option_i), .wait_mode_i(wait_mode_i),
        .stop_mode_i(stop_mode_i), .tick_irq_o(tick_irq_o), .stop_wakeup_o(stop_wakeup_o));

    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Ready and data are taken at the rising edge that completes the access, then released.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (n >= 20) begin
            failures++;
            give_verdict();
        end
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0);
        check("read data", rd, exp);
        check("bus error", {31'h0, er}, {31'h0, e});
    endtask

    // Slow reference pulses leave room for the two-flop synchroniser.
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge mclk_i);
            reference_clock_i <= 1'b1;
            repeat (4) @(posedge mclk_i);
            reference_clock_i <= 1'b0;
            repeat (4) @(posedge mclk_i);
        end
        repeat (6) @(posedge mclk_i);
    endtask

    task automatic irq_is(input logic e);
        repeat (3) @(posedge mclk_i);
        @(negedge mclk_i);
        check("irq", {31'h0, tick_irq_o}, {31'h0, e});
        @(posedge mclk_i);
    endtask

    initial begin
        failures = 0;
        compares = 0;
        reset_n_i = 1'b0;
        ce_i = 1'b1;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 12'h000;
        pwdata_i = 32'h0;
        pstrb_i = 4'hF;
        reference_clock_i = 1'b0;
        extra_prescale_option_i = 1'b0;
        osc_in_stop_option_i = 1'b0;
        wait_mode_i = 1'b0;
        stop_mode_i = 1'b0;
        repeat (8) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        rchk(12'h000, 32'h0, 1'b0);
        for (int i = 0; i < 16; i++) begin
            extra_prescale_option_i <= rows[i][27];
            apb(1'b1, 12'h000, {25'h0, rows[i][26:24], 4'h0});
            repeat (3) @(posedge mclk_i);
            rchk(12'h00C, {8'h0, rows[i][23:0]}, 1'b0);
        end
        extra_prescale_option_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        apb(1'b1, 12'h000, 32'h76);
        pulses(3);
        irq_is(1'b0);
        pulses(1);
        irq_is(1'b1);
        rchk(12'h004, 32'h1, 1'b0);
        rchk(12'h000, 32'hF6, 1'b0);
        apb(1'b1, 12'h000, 32'hF6);
        rchk(12'h000, 32'hF6, 1'b0);
        apb(1'b1, 12'h000, 32'h7E);
        rchk(12'h000, 32'h76, 1'b0);
        pulses(7);
        irq_is(1'b0);
        pulses(1);
        irq_is(1'b1);
        apb(1'b1, 12'h000, 32'h7E);
        wait_mode_i <= 1'b1;
        rchk(12'h000, 32'h0, 1'b1);
        pulses(8);
        irq_is(1'b1);
        wait_mode_i <= 1'b0;
        apb(1'b1, 12'h000, 32'h7E);
        stop_mode_i <= 1'b1;
        pulses(8);
        irq_is(1'b0);
        rchk(12'h000, 32'h0, 1'b1);
        osc_in_stop_option_i <= 1'b1;
        pulses(8);
        irq_is(1'b1);
        check("wakeup", {31'h0, stop_wakeup_o}, 32'h1);
        stop_mode_i <= 1'b0;
        osc_in_stop_option_i <= 1'b0;
        apb(1'b1, 12'h000, 32'hFC);
        rchk(12'h000, 32'h74, 1'b0);
        rchk(12'h008, 32'h0, 1'b0);
        apb(1'b1, 12'h000, 32'h72);
        pulses(3);
        rchk(12'h000, 32'h72, 1'b0);
        pulses(1);
        rchk(12'h000, 32'hF2, 1'b0);
        irq_is(1'b0);
        apb(1'b1, 12'h000, 32'h76);
        irq_is(1'b1);
        rchk(12'h010, 32'h0, 1'b1);
        give_verdict();
    end
endmodule
